// ### common/rarx_defines.vh
// Purpose: shared constants of the return and rotate execution block
// Assumes: 8-bit data path, one instruction cycle per enabled clock
// Notes:   included by its bare name
`ifndef RARX_DEFINES_VH
`define RARX_DEFINES_VH

// ****************************************************************
// instruction select codes
// ****************************************************************
`define RARX_OP_RETURN        2'h0
`define RARX_OP_RETURN_LIT    2'h1
`define RARX_OP_RETURN_IRQ    2'h2
`define RARX_OP_ROTATE_LEFT   2'h3

// ****************************************************************
// field positions and destination select codes
// ****************************************************************
`define RARX_IRQ_ALLOW_BIT    7
`define RARX_MSB_BIT          7
`define RARX_DEST_ACC         1'h0
`define RARX_DEST_FILE        1'h1

// ****************************************************************
// timing counts, in instruction cycles
// ****************************************************************
`define RARX_RET_CYCLES       2'h2
`define RARX_ROTATE_CYCLES    2'h1

// ****************************************************************
// reset values
// ****************************************************************
`define RARX_ACC_RST          8'h00
`define RARX_IRQ_CTRL_RST     8'h00
`define RARX_CARRY_RST        1'h0

`endif

// ### logic/rarx_exec.v
// Purpose: executes subroutine exit, return with literal, return from
//          interrupt and rotate left through carry for an 8-bit core
// Assumes: all inputs come from logic on clk; clk_en is the
//          instruction cycle enable
// Notes:   owns accumulator, carry, irq control register and call stack
//
// Overview of operation
// - Return from irq pops the stack into pc, taking 2 cycles.
// - Return from irq also sets global_irq_allow, bit 7 of irq control.
// - Return with literal writes its 8-bit literal into the accumulator.
// - Return with literal also pops the stack into pc in 2 cycles.
// - Subroutine exit pops the stack into pc in 2 cycles, nothing else.
// - Rotate left shifts file data left, carry into bit 0, msb to carry.
// - Rotate left result goes to acc when dest is 0, to file when 1.
// - Rotate left takes file address 0 to 127, 1 cycle, carry only.
`timescale 1ns/10ps
`include "rarx_defines.vh"

module rarx_exec #(
  parameter PC_W     = 15,
  parameter STACK_AW = 3,
  parameter ADDR_W   = 7
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire              clk_en,
  input  wire              instr_valid,
  input  wire [1:0]        instr_op,
  input  wire [7:0]        instr_literal,
  input  wire [ADDR_W-1:0] instr_file_addr,
  input  wire              instr_dest,
  input  wire [7:0]        file_rd_data,
  input  wire              call_push,
  input  wire [PC_W-1:0]   call_ret_addr,
  input  wire              irq_ctrl_wr,
  input  wire [7:0]        irq_ctrl_wr_data,
  output reg  [PC_W-1:0]   pc_ff,
  output reg  [7:0]        acc_ff,
  output reg               carry_ff,
  output reg  [7:0]        irq_control_reg_ff,
  output reg               file_wr_en_ff,
  output reg  [ADDR_W-1:0] file_wr_addr_ff,
  output reg  [7:0]        file_wr_data_ff,
  output reg               busy_ff,
  output reg               done_ff
);

  localparam STACK_DEPTH = 1 << STACK_AW;
  localparam ST_IDLE     = 1'b0;
  localparam ST_POP      = 1'b1;

  // ****************************************************************
  // state and storage
  // ****************************************************************
  reg [PC_W-1:0]     stack_mem [0:STACK_DEPTH-1];
  reg [STACK_AW-1:0] sp_ff;
  reg                state_ff;
  reg [1:0]          cyc_ff;
  reg [1:0]          op_ff;
  reg [7:0]          lit_ff;

  reg                nxt_state;
  reg [1:0]          nxt_cyc;
  reg [PC_W-1:0]     nxt_pc;
  reg [7:0]          nxt_acc;
  reg                nxt_carry;
  reg [7:0]          nxt_irq_ctrl;
  reg                nxt_wr_en;
  reg [ADDR_W-1:0]   nxt_wr_addr;
  reg [7:0]          nxt_wr_data;
  reg                nxt_done;
  reg [STACK_AW-1:0] nxt_sp;
  reg                do_push;

  wire [STACK_AW-1:0] top_idx;
  wire [PC_W-1:0]     stack_top_entry;
  wire [7:0]          rot_result;
  wire                accept;

  // ****************************************************************
  // stack top and request acceptance
  // ****************************************************************
  assign top_idx         = sp_ff - {{(STACK_AW-1){1'b0}}, 1'b1};
  assign stack_top_entry = stack_mem[top_idx];
  assign accept          = instr_valid && (state_ff == ST_IDLE);

  assign rot_result = {file_rd_data[`RARX_MSB_BIT-1:0], carry_ff};

  // ****************************************************************
  // next state
  // ****************************************************************
  always @* begin
    nxt_state    = state_ff;
    nxt_cyc      = cyc_ff;
    nxt_pc       = pc_ff;
    nxt_acc      = acc_ff;
    nxt_carry    = carry_ff;
    nxt_irq_ctrl = irq_control_reg_ff;
    nxt_wr_en    = 1'b0;
    nxt_wr_addr  = file_wr_addr_ff;
    nxt_wr_data  = file_wr_data_ff;
    nxt_done     = 1'b0;
    nxt_sp       = sp_ff;
    do_push      = 1'b0;
    if (irq_ctrl_wr) begin
      nxt_irq_ctrl = irq_ctrl_wr_data;
    end
    case (state_ff)
      ST_IDLE: begin
        if (accept && instr_op == `RARX_OP_ROTATE_LEFT) begin
          nxt_carry = file_rd_data[`RARX_MSB_BIT];
          nxt_done  = 1'b1;
          if (instr_dest == `RARX_DEST_ACC) begin
            nxt_acc = rot_result;
          end else begin
            nxt_wr_en   = 1'b1;
            nxt_wr_addr = instr_file_addr;
            nxt_wr_data = rot_result;
          end
        end else if (accept) begin
          nxt_state = ST_POP;
          nxt_cyc   = 2'h1;
        end else if (call_push) begin
          do_push = 1'b1;
          nxt_sp  = sp_ff + {{(STACK_AW-1){1'b0}}, 1'b1};
        end
      end
      ST_POP: begin
        nxt_cyc = cyc_ff + 2'h1;
        if (cyc_ff == `RARX_RET_CYCLES - 2'h1) begin
          nxt_pc    = stack_top_entry;
          nxt_sp    = top_idx;
          nxt_state = ST_IDLE;
          nxt_cyc   = 2'h0;
          nxt_done  = 1'b1;
          // no flag change here; acc takes the literal only on return with literal
          case (op_ff)
            `RARX_OP_RETURN_LIT: nxt_acc = lit_ff;
            `RARX_OP_RETURN_IRQ:
              nxt_irq_ctrl[`RARX_IRQ_ALLOW_BIT] = 1'b1;
            default: nxt_acc = acc_ff;
          endcase
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cyc   = 2'h0;
      end
    endcase
  end

  // ****************************************************************
  // sequencer registers
  // ****************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      cyc_ff   <= 2'h0;
      sp_ff    <= {STACK_AW{1'b0}};
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cyc_ff   <= nxt_cyc;
      sp_ff    <= nxt_sp;
      busy_ff  <= (nxt_state == ST_POP);
      done_ff  <= nxt_done;
    end
  end

  // ****************************************************************
  // request capture, held for the second return cycle
  // ****************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_ff  <= `RARX_OP_RETURN;
      lit_ff <= 8'h00;
    end else if (clk_en && accept) begin
      op_ff  <= instr_op;
      lit_ff <= instr_literal;
    end
  end

  // ****************************************************************
  // core registers
  // ****************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_ff              <= {PC_W{1'b0}};
      acc_ff             <= `RARX_ACC_RST;
      carry_ff           <= `RARX_CARRY_RST;
      irq_control_reg_ff <= `RARX_IRQ_CTRL_RST;
    end else if (clk_en) begin
      pc_ff              <= nxt_pc;
      acc_ff             <= nxt_acc;
      carry_ff           <= nxt_carry;
      irq_control_reg_ff <= nxt_irq_ctrl;
    end
  end

  // ****************************************************************
  // file write port
  // ****************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      file_wr_en_ff   <= 1'b0;
      file_wr_addr_ff <= {ADDR_W{1'b0}};
      file_wr_data_ff <= 8'h00;
    end else if (clk_en) begin
      file_wr_en_ff   <= nxt_wr_en;
      file_wr_addr_ff <= nxt_wr_addr;
      file_wr_data_ff <= nxt_wr_data;
    end
  end

  // ****************************************************************
  // call stack storage, no reset needed
  // ****************************************************************
  always @(posedge clk) begin
    if (clk_en && do_push) begin
      stack_mem[sp_ff] <= call_ret_addr;
    end
  end

endmodule

// ### tb/rarx_exec_asserts.sv
// Purpose: port assertions for rarx_exec
// Assumes: clk_en only dropped by the bench while idle
// Notes:   bound to every rarx_exec
`timescale 1ns/10ps
module rarx_exec_asserts #(
  parameter PC_W = 15
) (
  input logic            clk,
  input logic            reset_n,
  input logic            clk_en,
  input logic            instr_valid,
  input logic [1:0]      instr_op,
  input logic [7:0]      instr_literal,
  input logic [7:0]      file_rd_data,
  input logic            instr_dest,
  input logic            carry_ff,
  input logic            file_wr_en_ff,
  input logic [PC_W-1:0] pc_ff,
  input logic [7:0]      acc_ff,
  input logic [7:0]      irq_control_reg_ff,
  input logic [7:0]      file_wr_data_ff,
  input logic            busy_ff,
  input logic            done_ff
);
  wire       tk  = clk_en & instr_valid & ~busy_ff;
  wire       rot = tk & (instr_op == 2'h3);
  wire       ret = tk & (instr_op != 2'h3);
  wire [7:0] rl  = {file_rd_data[6:0], carry_ff};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_ROT_CY:
    assert property (rot |=> done_ff && carry_ff == $past(file_rd_data[7]))
    else $error("rotate carry or done wrong");
  AST_ROT_ACC:
    assert property (rot && !instr_dest |=> acc_ff == $past(rl))
    else $error("rotate to acc wrong");
  AST_ROT_FILE:
    assert property (rot && instr_dest |=> file_wr_en_ff &&
      file_wr_data_ff == $past(rl) && $stable(acc_ff))
    else $error("rotate to file wrong");
  AST_RET_TIME:
    assert property (ret |=> busy_ff && !done_ff ##1 done_ff && !busy_ff)
    else $error("return timing wrong");
  AST_RET_LIT:
    assert property (ret && instr_op == 2'h1 |=> ##1
      acc_ff == $past(instr_literal, 2))
    else $error("literal not in acc");
  AST_RET_IRQ:
    assert property (ret && instr_op == 2'h2 |=> ##1 irq_control_reg_ff[7])
    else $error("irq allow not set");
  AST_RET_FLAG:
    assert property (ret |=> $stable(carry_ff) [*2])
    else $error("return changed carry");
  AST_PC_CHG:
    assert property ($changed(pc_ff) |-> done_ff && $past(busy_ff))
    else $error("pc changed outside return");
endmodule

bind rarx_exec rarx_exec_asserts #(.PC_W(PC_W)) rarx_exec_asserts_i (
  .clk, .reset_n, .clk_en, .instr_valid, .instr_op, .instr_literal,
  .file_rd_data, .instr_dest, .carry_ff, .file_wr_en_ff, .pc_ff, .acc_ff,
  .irq_control_reg_ff, .file_wr_data_ff, .busy_ff, .done_ff);

// ### tb/rarx_exec_tb_top.sv
// Purpose: self-checking bench for rarx_exec
// Assumes: clk_en dropped only while the block is idle
// Notes:   bench stack model predicts pc
`timescale 1ns/10ps
module rarx_exec_tb_top;
  reg         clk = 0, reset_n = 0, iv = 0, dest = 0, cy_m = 0;
  reg         push = 0, iw = 0, ce = 1;
  reg  [1:0]  op = 0;
  reg  [7:0]  lit = 0, frd = 0, iwd = 0, acc_m = 0, irq_m = 0;
  reg  [6:0]  fa = 0;
  reg  [14:0] ra = 0, pc_m = 0, stk [0:7];
  reg  [2:0]  sp_m = 0;
  wire [14:0] pc;
  wire [7:0]  acc, irq, wd;
  wire [6:0]  wa;
  wire        cy, we, busy, done;
  integer     failures = 0, check_count = 0, i;
  always #4 clk = ~clk;
  rarx_exec rarx_exec_i (.clk, .reset_n, .clk_en(ce), .instr_valid(iv),
    .instr_op(op), .instr_literal(lit), .instr_file_addr(fa),
    .instr_dest(dest), .file_rd_data(frd), .call_push(push),
    .call_ret_addr(ra), .irq_ctrl_wr(iw), .irq_ctrl_wr_data(iwd),
    .pc_ff(pc), .acc_ff(acc), .carry_ff(cy), .irq_control_reg_ff(irq),
    .file_wr_en_ff(we), .file_wr_addr_ff(wa), .file_wr_data_ff(wd),
    .busy_ff(busy), .done_ff(done));
  task chk(input ok, input integer id);
    begin
      check_count = check_count + 1;
      if (!ok) begin
        failures = failures + 1;
        $display("unexpected at %0t: check %0d", $time, id);
      end
    end
  endtask
  // new carry on top, rotated value below
  function [8:0] rot_exp(input [7:0] f, input c);
    rot_exp = {f, c};
  endfunction
  // every output except file write address and data at its reset value
  task rst_chk;
    chk(pc === 15'h0 && acc === 8'h00 && cy === 1'h0 && irq === 8'h00 &&
      busy === 1'h0 && done === 1'h0 && we === 1'h0, 0);
  endtask
  // clk_en low for four edges: requests, push and irq write ignored
  task hold;
    begin
      @(posedge clk);
      {ce, iv, push, iw} <= 4'h7;
      {op, frd, iwd} <= {2'($urandom), 8'($urandom), 8'($urandom)};
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(pc === pc_m && acc === acc_m && cy === cy_m && irq === irq_m &&
        done === 1'h0 && we === 1'h0 && busy === 1'h0, 4);
      @(posedge clk);
      {ce, iv, push, iw} <= 4'h8;
    end
  endtask
  // push a return address and load irq control in one cycle
  task prep(input [14:0] a, input [7:0] w);
    begin
      @(posedge clk);
      {push, iw, ra, iwd} <= {2'h3, a, w};
      @(posedge clk);
      {push, iw} <= 2'h0;
      stk[sp_m] = a;
      sp_m = sp_m + 3'h1;
      irq_m = w;
    end
  endtask
  task run(input [1:0] o, input [7:0] k, input d, input [7:0] f);
    reg [7:0] r;
    begin
      @(posedge clk);
      {iv, op, lit, dest, frd, fa} <= {1'h1, o, k, d, f, 7'($urandom)};
      @(posedge clk);
      iv <= 1'h0;
      if (o != 2'h3) @(posedge clk);
      @(negedge clk);
      if (o == 2'h3) begin
        {cy_m, r} = rot_exp(f, cy_m);
        if (!d) acc_m = r;
        chk(we === d && (!d || (wd === r && wa === fa)), 1);
      end else begin
        sp_m = sp_m - 3'h1;
        pc_m = stk[sp_m];
        if (o == 2'h1) acc_m = k;
        if (o == 2'h2) irq_m[7] = 1'h1;
        chk(pc === pc_m && irq === irq_m, 2);
      end
      chk(acc === acc_m && cy === cy_m && done === 1'h1, 3);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    void'($urandom(32'h37E5A636));
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    @(negedge clk);
    rst_chk;
    run(2'h3, 8'h00, 1'h0, 8'hE6);
    run(2'h3, 8'h00, 1'h1, 8'hE6);
    prep(15'h7FFF, 8'h00);
    run(2'h1, 8'hFF, 1'h0, 8'h00);
    hold;
    for (i = 0; i < 48; i = i + 1) begin
      prep(15'($urandom), 8'($urandom) & 8'h7F);
      run(i[1:0], 8'($urandom), 1'($urandom), 8'($urandom));
    end
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    {sp_m, pc_m, acc_m, cy_m, irq_m} = 35'h0;
    @(negedge clk);
    rst_chk;
    run(2'h3, 8'h00, 1'h0, 8'hE6);
    summarize;
  end
  initial begin
    #20000;
    failures = failures + 1;
    summarize;
  end
endmodule
